// ==== rtl/sbatc_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SBATC_DEFS_SVH
`define SBATC_DEFS_SVH
`define SBATC_BLK0_OFS     12'h108
`define SBATC_BLK1_OFS     12'h110
`define SBATC_STAT_OFS     12'h118
`define SBATC_BASE_MSB     31
`define SBATC_BASE_LSB     18
`define SBATC_RFSH_BIT     15
`define SBATC_COLUMN_LATENCY_SEL_MSB     13
`define SBATC_COLUMN_LATENCY_SEL_LSB     12
`define SBATC_CTRL_WMASK   32'hFFFC_B000
`define SBATC_RFSH_RST     1'b0
`define SBATC_CLK_NS       100
`define SBATC_RCD_L0       4'h1
`define SBATC_RCD_L1       4'h2
`define SBATC_RCD_L2       4'h3
`define SBATC_RAS_L0       4'h2
`define SBATC_RAS_L1       4'h4
`define SBATC_RAS_L2       4'h6
`endif

// ==== rtl/sbatc_pkg.sv ====
// Types shared by the block address and timing control logic
`default_nettype none
package sbatc_pkg;
   typedef logic [1:0]  sbatc_lat_t;
   typedef logic [13:0] sbatc_base_t;
   typedef logic [3:0]  sbatc_cnt_t;
   typedef enum logic [2:0]
   {
      SBATC_IDLE  = 3'b000,
      SBATC_ACT   = 3'b001,
      SBATC_COL   = 3'b010,
      SBATC_DATA  = 3'b011,
      SBATC_PRE   = 3'b100
   } sbatc_state_e;
endpackage
`default_nettype wire

// ==== rtl/sbatc_blk_timer.sv ====
// Per-block access sequencer applying latency-coded SDRAM spacing
`default_nettype none
`include "sbatc_defs.svh"
module sbatc_blk_timer
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire sbatc_pkg::sbatc_lat_t lat,
   input  wire logic                access_req,
   input  wire logic                rfsh_req,
   input  wire logic                rfsh_allow,
   output logic                     row_strobe,
   output logic                     column_strobe,
   output logic                     activate_cmd,
   output logic                     precharge_cmd,
   output logic                     refresh_cmd,
   output logic                     data_capture,
   output logic                     busy
);
   import sbatc_pkg::*;

   sbatc_state_e state_reg;
   sbatc_state_e state_next;
   sbatc_cnt_t   cnt_reg;
   sbatc_cnt_t   cnt_next;
   sbatc_cnt_t   ras_reg;
   sbatc_cnt_t   ras_next;
   logic [5:0]   out_reg;
   logic [5:0]   out_next;
   sbatc_cnt_t   rcd;
   sbatc_cnt_t   ras_min;

   always_comb
   begin
      rcd     = (lat == 2'h0) ? `SBATC_RCD_L0 :
                (lat == 2'h1) ? `SBATC_RCD_L1 : `SBATC_RCD_L2;
      ras_min = (lat == 2'h0) ? `SBATC_RAS_L0 :
                (lat == 2'h1) ? `SBATC_RAS_L1 : `SBATC_RAS_L2;
   end

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : cnt_reg;
      ras_next   = (ras_reg != 4'h0) ? ras_reg - 4'h1 : ras_reg;
      out_next   = 6'h00;
      case (state_reg)
         SBATC_IDLE:
         begin
            if (cnt_reg == 4'h0)
            begin
               if (rfsh_req && rfsh_allow)
               begin
                  out_next[4] = 1'b1;
                  cnt_next    = rcd;
               end
               else if (access_req)
               begin
                  out_next[0] = 1'b1;
                  out_next[2] = 1'b1;
                  cnt_next    = rcd - 4'h1;
                  ras_next    = ras_min - 4'h1;
                  state_next  = SBATC_ACT;
               end
            end
         end
         SBATC_ACT:
         begin
            if (cnt_reg == 4'h0)
            begin
               out_next[1] = 1'b1;
               cnt_next    = rcd - 4'h1;
               state_next  = SBATC_COL;
            end
         end
         SBATC_COL:
         begin
            if (cnt_reg == 4'h0)
            begin
               out_next[5] = 1'b1;
               state_next  = SBATC_DATA;
            end
         end
         SBATC_DATA:
         begin
            if (ras_reg == 4'h0)
            begin
               out_next[3] = 1'b1;
               cnt_next    = rcd;
               state_next  = SBATC_PRE;
            end
         end
         SBATC_PRE:
         begin
            state_next = SBATC_IDLE;
         end
         default:
         begin
            state_next = SBATC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= SBATC_IDLE;
         cnt_reg   <= 4'h0;
         ras_reg   <= 4'h0;
         out_reg   <= 6'h00;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         ras_reg   <= ras_next;
         out_reg   <= out_next;
      end
   end

   assign row_strobe    = out_reg[0];
   assign column_strobe = out_reg[1];
   assign activate_cmd  = out_reg[2];
   assign precharge_cmd = out_reg[3];
   assign refresh_cmd   = out_reg[4];
   assign data_capture  = out_reg[5];
   assign busy          = (state_reg != SBATC_IDLE) || (cnt_reg != 4'h0);
endmodule
`default_nettype wire

// ==== rtl/sbatc_top.sv ====
// Two-block SDRAM address match and timing control with AHB-Lite registers
// Notes on behaviour
// - Unmasked base bits must equal bus address
// - Refresh a block only when enabled
// - Row-to-column delay 1,2,3,3 clocks
// - Read data expected 1,2,3,3 clocks later
// - Activate-to-precharge at least 2,4,6,6 clocks
// - Two control registers at 0x108, 0x110
// - Precharge-to-activate wait 2,3,4,4 clocks
`default_nettype none
`include "sbatc_defs.svh"
module sbatc_top
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [31:0]         mem_addr,
   input  wire logic                mem_valid,
   input  wire logic [13:0]         match_mask,
   input  wire logic                rfsh_tick,
   output logic [1:0]               block_hit,
   output logic [1:0]               row_strobe,
   output logic [1:0]               column_strobe,
   output logic [1:0]               activate_cmd,
   output logic [1:0]               precharge_cmd,
   output logic [1:0]               refresh_cmd,
   output logic [1:0]               data_capture,
   output logic [1:0]               block_busy
);
   import sbatc_pkg::*;

   logic [31:0] ctrl_reg [2];
   logic [31:0] ctrl_next [2];
   logic        wpend_reg;
   logic        wpend_next;
   logic [11:0] waddr_reg;
   logic [11:0] waddr_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic [1:0]  hit_reg;
   logic [1:0]  hit_next;
   logic [1:0]  rfsh_pend_reg;
   logic [1:0]  rfsh_pend_next;
   logic        take;
   logic [1:0]  rfsh_sent;

   assign take = hsel && hready && htrans[1];

   // Register bus: writes land one cycle later, reads are zero wait
   always_comb
   begin
      ctrl_next[0] = ctrl_reg[0];
      ctrl_next[1] = ctrl_reg[1];
      wpend_next   = take && hwrite;
      waddr_next   = take ? haddr[11:0] : waddr_reg;
      hrdata_next  = hrdata_reg;
      if (wpend_reg)
      begin
         if (waddr_reg == `SBATC_BLK0_OFS)
         begin
            ctrl_next[0] = hwdata & `SBATC_CTRL_WMASK;
         end
         else if (waddr_reg == `SBATC_BLK1_OFS)
         begin
            ctrl_next[1] = hwdata & `SBATC_CTRL_WMASK;
         end
      end
      if (take && !hwrite)
      begin
         if (haddr[11:0] == `SBATC_BLK0_OFS)
         begin
            hrdata_next = ctrl_reg[0];
         end
         else if (haddr[11:0] == `SBATC_BLK1_OFS)
         begin
            hrdata_next = ctrl_reg[1];
         end
         else if (haddr[11:0] == `SBATC_STAT_OFS)
         begin
            hrdata_next = {28'h0000000, rfsh_pend_reg, block_busy};
         end
         else
         begin
            hrdata_next = 32'h0000_0000;
         end
      end
   end

   // Address compare per block and refresh request latching
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         hit_next[b] = mem_valid &&
            (((mem_addr[`SBATC_BASE_MSB:`SBATC_BASE_LSB]
               ^ ctrl_reg[b][`SBATC_BASE_MSB:`SBATC_BASE_LSB]) & ~match_mask)
               == 14'h0000);
         rfsh_pend_next[b] = ctrl_reg[b][`SBATC_RFSH_BIT] &&
            ((rfsh_pend_reg[b] && !rfsh_sent[b]) || rfsh_tick);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl_reg[0]   <= 32'h0000_0000;
         ctrl_reg[1]   <= 32'h0000_0000;
         wpend_reg     <= 1'b0;
         waddr_reg     <= 12'h000;
         hrdata_reg    <= 32'h0000_0000;
         hit_reg       <= 2'h0;
         rfsh_pend_reg <= 2'h0;
      end
      else if (ce)
      begin
         ctrl_reg[0]   <= ctrl_next[0];
         ctrl_reg[1]   <= ctrl_next[1];
         wpend_reg     <= wpend_next;
         waddr_reg     <= waddr_next;
         hrdata_reg    <= hrdata_next;
         hit_reg       <= hit_next;
         rfsh_pend_reg <= rfsh_pend_next;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign block_hit = hit_reg;
   assign rfsh_sent = refresh_cmd;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_blk
         sbatc_blk_timer u_timer
         (
            .clk           (clk),
            .rst_n         (rst_n),
            .ce            (ce),
            .lat           (ctrl_reg[g][`SBATC_COLUMN_LATENCY_SEL_MSB:`SBATC_COLUMN_LATENCY_SEL_LSB]),
            .access_req    (hit_reg[g]),
            .rfsh_req      (rfsh_pend_reg[g]),
            .rfsh_allow    (ctrl_reg[g][`SBATC_RFSH_BIT]),
            .row_strobe    (row_strobe[g]),
            .column_strobe (column_strobe[g]),
            .activate_cmd  (activate_cmd[g]),
            .precharge_cmd (precharge_cmd[g]),
            .refresh_cmd   (refresh_cmd[g]),
            .data_capture  (data_capture[g]),
            .busy          (block_busy[g])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ==== test/sbatc_top_sva.sv ====
// Concurrent checks on address match and access timing outputs
`default_nettype none
module sbatc_top_sva
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        mem_valid,
   input wire logic [13:0] match_mask,
   input wire logic [1:0]  block_hit,
   input wire logic [1:0]  row_strobe,
   input wire logic [1:0]  column_strobe,
   input wire logic [1:0]  activate_cmd,
   input wire logic [1:0]  precharge_cmd,
   input wire logic [1:0]  refresh_cmd,
   input wire logic [1:0]  data_capture
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rcd_blk1: assert property (row_strobe[1] |-> ##[1:3] column_strobe[1])
      else $error("column strobe late on block 1");
   a_rcd_win: assert property (activate_cmd[0] |-> ##[1:3] column_strobe[0])
      else $error("column strobe late");
   a_cas_data: assert property (column_strobe[0] |-> ##[1:3] data_capture[0])
      else $error("data capture late");
   a_ras_min: assert property (activate_cmd[0] |=> !precharge_cmd[0])
      else $error("precharge too soon");
   a_rp_gap: assert property (precharge_cmd[1] |=> !activate_cmd[1])
      else $error("activate too soon");
   a_hit_mask: assert property (mem_valid && match_mask == 14'h3FFF |=> block_hit == 2'b11)
      else $error("masked access missed");
   a_hit_valid: assert property (block_hit[0] |-> $past(mem_valid))
      else $error("hit without access");
   a_rst_quiet: assert property (disable iff (1'b0) !rst_n |=> refresh_cmd == 2'b00)
      else $error("refresh after reset");
   c_col: cover property (column_strobe[0]);
   c_ref: cover property (refresh_cmd[1]);
   c_pre: cover property (precharge_cmd[1]);
endmodule
bind sbatc_top sbatc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .mem_valid(mem_valid),
   .match_mask(match_mask), .block_hit(block_hit), .row_strobe(row_strobe),
   .column_strobe(column_strobe), .activate_cmd(activate_cmd),
   .precharge_cmd(precharge_cmd), .refresh_cmd(refresh_cmd), .data_capture(data_capture));
`default_nettype wire

// ==== test/sbatc_sdram_mdl.sv ====
// Behavioural bank state of the SDRAM in both blocks
`default_nettype none
module sbatc_sdram_mdl
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] act,
   input  wire logic [1:0] pre,
   input  wire logic [1:0] col,
   input  wire logic [1:0] rfsh,
   output logic            bad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] open_reg;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         open_reg <= 2'h0;
         bad <= 1'b0;
      end
      else
      begin
         open_reg <= (open_reg | act) & ~pre;
         if ((act & open_reg) != 0 || (col & ~open_reg) != 0 || (rfsh & open_reg) != 0)
            bad <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== test/sbatc_top_tb.sv ====
// Testbench for block address match and timing control
`default_nettype none
module sbatc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0;
   logic        rst_n = 0;
   logic        hsel = 0;
   logic [31:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic        hwrite = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] mem_addr = 0;
   logic        mem_valid = 0;
   logic [13:0] match_mask = 0;
   logic        rfsh_tick = 0;
   logic        ce = 1;
   wire logic        hrdy;
   wire logic        hresp;
   wire logic        bad;
   wire logic [31:0] hrdata;
   wire logic [1:0]  hit, rs, cs, act, pre, rf, dc, busy;
   int n_errors = 0;
   int checks_done = 0;
   int seed = 32'hd036faab;
   always #50 clk = ~clk;
   sbatc_top dut(.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .match_mask(match_mask), .rfsh_tick(rfsh_tick),
      .block_hit(hit), .row_strobe(rs), .column_strobe(cs), .activate_cmd(act),
      .precharge_cmd(pre), .refresh_cmd(rf), .data_capture(dc), .block_busy(busy));
   sbatc_sdram_mdl mdl(.clk(clk), .rst_n(rst_n), .act(act), .pre(pre), .col(cs),
      .rfsh(rf), .bad(bad));
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrdy;
      int i;
      i = 0;
      @(posedge clk);
      while (hrdy !== 1'b1 && i < 50)
      begin
         i++;
         @(posedge clk);
      end
      if (i >= 50)
      begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wrdy();
      hsel <= 0;
      htrans <= 0;
      hwdata <= d;
      wrdy();
      r = hrdata;
   endtask
   function automatic int rcd(int l);
      return l == 0 ? 1 : l == 1 ? 2 : 3;
   endfunction
   initial
   begin
      logic [31:0] r, d, a;
      logic [13:0] ba;
      int t[5];
      int n;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      bus(0, 32'h108, 0, r);
      chk("refresh enable", r[15], 0);
      bus(0, 32'h200, 0, r);
      chk("unmapped", r, 0);
      for (int l = 0; l < 4; l++)
         for (int b = 0; b < 2; b++)
         begin
            a = b ? 32'h110 : 32'h108;
            d = $random(seed);
            bus(1, a, d, r);
            bus(0, a, 0, r);
            chk("ctrl reg", r, d & 32'hFFFC_B000);
            ba = $random(seed);
            bus(1, a, {ba, 4'h0, 2'(l), 12'h0}, r);
            mem_addr <= {ba, d[17:0]};
            mem_valid <= 1;
            t = '{-1, -1, -1, -1, -1};
            for (int c = 0; c < 40; c++)
            begin
               @(posedge clk);
               #1;
               if (rs[b] && t[0] < 0)
               begin
                  t[0] = c;
                  chk("busy", busy[b], 1);
               end
               if (cs[b] && t[1] < 0) t[1] = c;
               if (dc[b] && t[2] < 0) t[2] = c;
               if (pre[b] && t[3] < 0) t[3] = c;
               if (act[b] && t[3] >= 0 && t[4] < 0) t[4] = c;
               if (t[4] >= 0) mem_valid <= 0;
            end
            @(posedge clk);
            chk("row to column", t[1] - t[0], rcd(l));
            chk("column to data", t[2] - t[1], rcd(l));
            chk("activate to precharge", t[3] - t[0] >= 2 * rcd(l), 1);
            chk("precharge to activate", t[4] - t[3] > rcd(l), 1);
         end
      for (int b = 0; b < 2; b++)
      begin
         a = b ? 32'h110 : 32'h108;
         ba = $random(seed);
         bus(1, a, {ba, 18'h0}, r);
         mem_addr <= {~ba[13], ba[12:0], 18'h0};
         mem_valid <= 1;
         repeat (2) @(posedge clk);
         chk("miss", hit[b], 0);
         match_mask <= 14'h2000;
         repeat (2) @(posedge clk);
         chk("masked hit", hit[b], 1);
         match_mask <= 14'h3FFF;
         repeat (2) @(posedge clk);
         chk("all masked", hit, 2'b11);
         mem_valid <= 0;
         match_mask <= 0;
         for (int re = 0; re < 2; re++)
         begin
            bus(1, a, {ba, 2'b0, 1'(re), 15'h0}, r);
            rfsh_tick <= 1;
            @(posedge clk);
            rfsh_tick <= 0;
            n = 0;
            repeat (15)
            begin
               @(posedge clk);
               #1;
               n += rf[b];
            end
            @(posedge clk);
            chk("refresh issued", n > 0, re);
         end
      end
      bus(0, 32'h118, 0, r);
      chk("status idle", r, 0);
      chk("bus response", hresp, 0);
      bus(1, 32'h108, 32'h0000_8000, r);
      ce <= 0;
      bus(1, 32'h108, 32'hFFFF_FFFF, r);
      ce <= 1;
      bus(0, 32'h108, 0, r);
      chk("frozen write", r, 32'h0000_8000);
      chk("sdram protocol", bad, 0);
      summarize();
   end
endmodule
`default_nettype wire
